// File: hw/ebi_cfg_if.sv
`timescale 1ns/1ps
interface ebi_cfg_if;
  logic [31:0]      sys;
  logic [2:0][31:0] bus;
  logic [1:0][31:0] win;
  logic [23:0]      addr;
  logic [15:0]      wdata;
  logic [2:0]       cmd;
  logic             start;
  logic [31:0]      pdir;
  logic [31:0]      pout;
  logic [15:0]      p4;
  logic [31:0]      pin;
  logic [7:0]       p4in;
  logic             busy;
  logic             boot_ext;
  logic [15:0]      rdata;

  modport regs (output sys, bus, win, addr, wdata, cmd, start, pdir, pout, p4,
                input pin, p4in, busy, boot_ext, rdata);
  modport core (input sys, bus, win, addr, wdata, cmd, start, pdir, pout, p4,
                output pin, p4in, busy, boot_ext, rdata);
endinterface

// File: hw/ebi_clkdiv.sv
`timescale 1ns/1ps
module ebi_clkdiv (
  input  wire logic       hclk,    // cpu clock
  input  wire logic       hresetn, // async reset, low
  input  wire logic       en,      // divider running
  input  wire logic [3:0] div,     // half period minus one
  output logic            clk_pin  // divided clock
);
  logic [3:0] cnt;

  // period is 2*(div+1) cycles; a flop cannot pass hclk itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt     <= 4'h0;
      clk_pin <= 1'b0;
    end else if (!en) begin
      cnt     <= 4'h0;
      clk_pin <= 1'b0;
    end else if (cnt >= div) begin
      cnt     <= 4'h0;
      clk_pin <= !clk_pin;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // ebi_clkdiv

// File: hw/ebi_pkg.sv
package ebi_pkg;
  localparam logic [7:0] OFF_SYS   = 8'h00;
  localparam logic [7:0] OFF_BUS0  = 8'h04;
  localparam logic [7:0] OFF_BUS1  = 8'h08;
  localparam logic [7:0] OFF_BUS2  = 8'h0C;
  localparam logic [7:0] OFF_WIN1  = 8'h10;
  localparam logic [7:0] OFF_WIN2  = 8'h14;
  localparam logic [7:0] OFF_ADDR  = 8'h18;
  localparam logic [7:0] OFF_WDATA = 8'h1C;
  localparam logic [7:0] OFF_CMD   = 8'h20;
  localparam logic [7:0] OFF_STAT  = 8'h24;
  localparam logic [7:0] OFF_PDIR  = 8'h28;
  localparam logic [7:0] OFF_POUT  = 8'h2C;
  localparam logic [7:0] OFF_P4    = 8'h30;
  localparam logic [7:0] OFF_PIN   = 8'h34;
  // system_config_word fields
  localparam int SC_STYLE = 0;
  localparam int SC_RPOL  = 1;
  localparam int SC_CKEN  = 2;
  localparam int SC_DIV   = 8;
  localparam int SC_AN    = 16;
  localparam int SC_SEG   = 24;
  // bus_range_config fields
  localparam int BC_MUX = 0;
  localparam int BC_W16 = 1;
  localparam int BC_RDY = 2;
  // range_window_select fields
  localparam int RW_SIZE = 0;
  localparam int RW_EN   = 4;
  localparam int RW_BASE = 12;
  localparam int CM_WR   = 0;
  localparam int CM_BE   = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_BOOT = 1;
  localparam int ST_DATA = 16;
  localparam int P4_DIR  = 0;
  localparam int P4_OUT  = 8;
  localparam int P4_IN   = 16;
  localparam logic [31:0] SYS_RST  = 32'h0000_0000;
  localparam logic [31:0] BUS0_RST = 32'h0000_0003;
  localparam logic [31:0] REG_RST  = 32'h0000_0000;
  localparam logic [2:0]  CMD_RST  = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_STRB = 2'b11,
    ST_HOLD = 2'b10
  } ebi_state_t;

  typedef struct packed {
    logic [23:0] a;
    logic [15:0] d;
    logic        wr;
    logic [1:0]  be;
    logic        mux;
    logic        w16;
    logic        rdy;
    logic        lb;
  } ebi_acc_t;

  function automatic logic ebi_win_hit(input logic [23:0] a, input logic [31:0] w);
    logic [11:0] m;
    m = 12'hFFF << w[RW_SIZE +: 4];
    return w[RW_EN] && ((a[23:12] & m) == (w[RW_BASE +: 12] & m));
  endfunction
endpackage

// File: hw/ebi_regs.sv
`timescale 1ns/1ps
module ebi_regs (
  input  wire logic        hclk,      // cpu clock
  input  wire logic        hresetn,   // async reset, low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write
  input  wire logic [2:0]  hsize,     // word only
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic [31:0]      hrdata,    // read data
  output logic             hreadyout, // always ready
  output logic             hresp,     // always okay
  ebi_cfg_if.regs          cif        // towards the core
);
  logic       wr_pend;
  logic [7:0] wa;

  wire       take  = hsel && hready && htrans[1] && (hsize == 3'h2);
  wire [7:0] ra    = haddr[7:0];
  wire       s_sys = wa == ebi_pkg::OFF_SYS;
  wire       s_b0  = wa == ebi_pkg::OFF_BUS0;
  wire       s_b1  = wa == ebi_pkg::OFF_BUS1;
  wire       s_b2  = wa == ebi_pkg::OFF_BUS2;
  wire       s_w1  = wa == ebi_pkg::OFF_WIN1;
  wire       s_w2  = wa == ebi_pkg::OFF_WIN2;
  wire       s_ad  = wa == ebi_pkg::OFF_ADDR;
  wire       s_wd  = wa == ebi_pkg::OFF_WDATA;
  wire       s_cmd = wa == ebi_pkg::OFF_CMD;
  wire       s_dir = wa == ebi_pkg::OFF_PDIR;
  wire       s_out = wa == ebi_pkg::OFF_POUT;
  wire       s_p4  = wa == ebi_pkg::OFF_P4;
  wire [31:0] stat = {cif.rdata, 14'h0000, cif.boot_ext, cif.busy};
  wire [31:0] rd_mux =
    (ra == ebi_pkg::OFF_SYS)   ? cif.sys :
    (ra == ebi_pkg::OFF_BUS0)  ? cif.bus[0] :
    (ra == ebi_pkg::OFF_BUS1)  ? cif.bus[1] :
    (ra == ebi_pkg::OFF_BUS2)  ? cif.bus[2] :
    (ra == ebi_pkg::OFF_WIN1)  ? cif.win[0] :
    (ra == ebi_pkg::OFF_WIN2)  ? cif.win[1] :
    (ra == ebi_pkg::OFF_ADDR)  ? {8'h00, cif.addr} :
    (ra == ebi_pkg::OFF_WDATA) ? {16'h0000, cif.wdata} :
    (ra == ebi_pkg::OFF_CMD)   ? {29'h0, cif.cmd} :
    (ra == ebi_pkg::OFF_STAT)  ? stat :
    (ra == ebi_pkg::OFF_PDIR)  ? cif.pdir :
    (ra == ebi_pkg::OFF_POUT)  ? cif.pout :
    (ra == ebi_pkg::OFF_P4)    ? {8'h00, cif.p4in, cif.p4} :
    (ra == ebi_pkg::OFF_PIN)   ? cif.pin : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wa        <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= take && hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take) wa <= ra;
      if (take && !hwrite) hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cif.sys   <= ebi_pkg::SYS_RST;
      cif.bus   <= {ebi_pkg::REG_RST, ebi_pkg::REG_RST, ebi_pkg::BUS0_RST};
      cif.win   <= {ebi_pkg::REG_RST, ebi_pkg::REG_RST};
      cif.addr  <= 24'h00_0000;
      cif.wdata <= 16'h0000;
      cif.cmd   <= ebi_pkg::CMD_RST;
      cif.start <= 1'b0;
      cif.pdir  <= ebi_pkg::REG_RST;
      cif.pout  <= ebi_pkg::REG_RST;
      cif.p4    <= 16'h0000;
    end else begin
      // a command while an access runs is dropped
      cif.start <= wr_pend && s_cmd && !cif.busy && !cif.start;
      if (wr_pend && s_sys) cif.sys <= hwdata;
      if (wr_pend && s_b0) cif.bus[0] <= hwdata;
      if (wr_pend && s_b1) cif.bus[1] <= hwdata;
      if (wr_pend && s_b2) cif.bus[2] <= hwdata;
      if (wr_pend && s_w1) cif.win[0] <= hwdata;
      if (wr_pend && s_w2) cif.win[1] <= hwdata;
      if (wr_pend && s_ad) cif.addr <= hwdata[23:0];
      if (wr_pend && s_wd) cif.wdata <= hwdata[15:0];
      if (wr_pend && s_cmd && !cif.busy && !cif.start) cif.cmd <= hwdata[2:0];
      if (wr_pend && s_dir) cif.pdir <= hwdata;
      if (wr_pend && s_out) cif.pout <= hwdata;
      if (wr_pend && s_p4) cif.p4 <= hwdata[15:0];
    end
  end
endmodule // ebi_regs

// File: hw/ebi_top.sv
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module ebi_top (
  input  wire logic        hclk,                     // cpu clock
  input  wire logic        hresetn,                  // async reset, low
  input  wire logic        hsel,                     // ahb select
  input  wire logic [31:0] haddr,                    // ahb address
  input  wire logic [1:0]  htrans,                   // ahb transfer
  input  wire logic        hwrite,                   // ahb write
  input  wire logic [2:0]  hsize,                    // ahb size
  input  wire logic [31:0] hwdata,                   // ahb write data
  input  wire logic        hready,                   // ahb ready in
  output logic [31:0]      hrdata,                   // ahb read data
  output logic             hreadyout,                // ahb ready out
  output logic             hresp,                    // ahb response
  output logic             rd_n,                     // read strobe
  output logic             low_byte_store_strobe_n,  // write strobe
  output logic             upper_byte_enable_n,      // upper enable/strobe
  output logic             addr_latch,               // address latch
  input  wire logic        ready_in,                 // wait request
  input  wire logic        external_boot_select_n,   // boot pin
  output logic             boot_from_external,       // boot choice
  output logic             system_clock_pin,         // divided clock
  input  wire logic [7:0]  muxed_port_low_in,        // pin level
  output logic [7:0]       muxed_port_low_out,       // pin drive
  output logic [7:0]       muxed_port_low_oe,        // pin enable
  input  wire logic [7:0]  muxed_port_high_in,       // pin level
  output logic [7:0]       muxed_port_high_out,      // pin drive
  output logic [7:0]       muxed_port_high_oe,       // pin enable
  input  wire logic [7:0]  demux_addr_port_low_in,   // pin level
  output logic [7:0]       demux_addr_port_low_out,  // pin drive
  output logic [7:0]       demux_addr_port_low_oe,   // pin enable
  input  wire logic [7:0]  demux_addr_port_high_in,  // pin level
  output logic [7:0]       demux_addr_port_high_out, // pin drive
  output logic [7:0]       demux_addr_port_high_oe,  // pin enable
  input  wire logic [7:0]  seg_port_in,              // pin level
  output logic [7:0]       seg_port_out,             // pin drive
  output logic [7:0]       seg_port_oe               // pin enable
);
  ebi_cfg_if cif ();

  ebi_regs u_regs (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .cif       (cif.regs)
  );

  ebi_clkdiv u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (cif.sys[ebi_pkg::SC_CKEN]),
    .div     (cif.sys[ebi_pkg::SC_DIV +: 4]),
    .clk_pin (system_clock_pin)
  );

  ebi_pkg::ebi_state_t state;
  ebi_pkg::ebi_state_t next_state;
  ebi_pkg::ebi_acc_t   acc_q;
  ebi_pkg::ebi_acc_t   live;
  ebi_pkg::ebi_acc_t   c;
  logic                rdy_s1;
  logic                rdy_s2;
  logic                boot_done;

  assign cif.pin  = {demux_addr_port_high_in, demux_addr_port_low_in,
                     muxed_port_high_in, muxed_port_low_in};
  assign cif.p4in = seg_port_in;

  // first window wins, range 0 is the fallback
  wire        hit1 = ebi_pkg::ebi_win_hit(cif.addr, cif.win[0]);
  wire        hit2 = ebi_pkg::ebi_win_hit(cif.addr, cif.win[1]);
  wire [31:0] bsel = hit1 ? cif.bus[1] : (hit2 ? cif.bus[2] : cif.bus[0]);

  assign live = '{a:   cif.addr,
                  d:   cif.wdata,
                  wr:  cif.cmd[ebi_pkg::CM_WR],
                  be:  cif.cmd[ebi_pkg::CM_BE +: 2],
                  mux: bsel[ebi_pkg::BC_MUX],
                  w16: bsel[ebi_pkg::BC_W16],
                  rdy: bsel[ebi_pkg::BC_RDY],
                  lb:  cif.sys[ebi_pkg::SC_STYLE]};
  // parameters freeze for the whole access
  assign c = (state == ebi_pkg::ST_IDLE) ? live : acc_q;

  wire rpol     = cif.sys[ebi_pkg::SC_RPOL];
  wire wait_now = c.rdy && (rdy_s2 != rpol);

  always_comb begin
    next_state = state;
    case (state)
      ebi_pkg::ST_IDLE: if (cif.start) next_state = ebi_pkg::ST_ADDR;
      ebi_pkg::ST_ADDR: next_state = ebi_pkg::ST_STRB;
      ebi_pkg::ST_STRB: if (!wait_now) next_state = ebi_pkg::ST_HOLD;
      ebi_pkg::ST_HOLD: next_state = ebi_pkg::ST_IDLE;
      default:          next_state = ebi_pkg::ST_IDLE;
    endcase
  end

  // second stage only; the first is a pure synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      rdy_s1 <= ready_in;
      rdy_s2 <= rdy_s1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ebi_pkg::ST_IDLE;
      acc_q <= '0;
    end else begin
      state <= next_state;
      if (state == ebi_pkg::ST_IDLE) acc_q <= live;
    end
  end

  assign cif.busy     = state != ebi_pkg::ST_IDLE;
  assign cif.boot_ext = boot_from_external;

  wire        cap     = state == ebi_pkg::ST_STRB && !wait_now && !c.wr;
  wire [15:0] rd_word = c.w16 ? {muxed_port_high_in, muxed_port_low_in}
                              : {8'h00, muxed_port_low_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cif.rdata <= 16'h0000;
    end else if (cap) begin
      cif.rdata <= rd_word;
    end
  end

  // boot pin taken at the first edge after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_done          <= 1'b0;
      boot_from_external <= 1'b0;
    end else if (!boot_done) begin
      boot_done          <= 1'b1;
      boot_from_external <= !external_boot_select_n;
    end
  end

  // pins follow the next state so they line up with state
  wire acc    = next_state != ebi_pkg::ST_IDLE;
  wire adr_ph = next_state == ebi_pkg::ST_ADDR;
  wire strb   = next_state == ebi_pkg::ST_STRB;
  wire dat_wr = acc && !adr_ph && c.wr;
  wire hi_be  = c.w16 && c.be[1];

  wire next_rd_n = !(strb && !c.wr);
  wire next_wr_n = !(strb && c.wr && (!c.lb || !c.w16 || c.be[0]));
  wire next_ub_n = c.lb ? !(strb && c.wr && hi_be) : !(acc && hi_be);
  wire next_ale  = adr_ph;

  // an 8-bit bus carries a lone high byte on the low lane
  wire [7:0] dlo = (!c.w16 && !c.be[0]) ? c.d[15:8] : c.d[7:0];
  wire next_l_oe_bus = (c.mux && adr_ph) || dat_wr;
  wire [7:0] next_l_oe  = acc ? {8{next_l_oe_bus}} : cif.pdir[7:0];
  wire [7:0] next_l_out = acc ? (adr_ph ? c.a[7:0] : dlo) : cif.pout[7:0];

  wire hi_own = acc && (c.w16 || c.mux);
  wire hi_adr = c.mux && (adr_ph || !c.w16);
  wire [7:0] next_h_oe  = hi_own ? {8{hi_adr || dat_wr}} : cif.pdir[15:8];
  wire [7:0] next_h_out = hi_own ? (hi_adr ? c.a[15:8] : c.d[15:8])
                                 : cif.pout[15:8];

  wire any_demux = !cif.bus[0][ebi_pkg::BC_MUX]
                 || (cif.win[0][ebi_pkg::RW_EN] && !cif.bus[1][ebi_pkg::BC_MUX])
                 || (cif.win[1][ebi_pkg::RW_EN] && !cif.bus[2][ebi_pkg::BC_MUX]);
  wire [7:0]  an_sel   = cif.sys[ebi_pkg::SC_AN +: 8];
  wire [15:0] p1_oe    = any_demux ? 16'hFFFF : cif.pdir[31:16];
  wire [15:0] p1_out   = any_demux ? c.a[15:0] : cif.pout[31:16];
  wire        seg_en   = cif.sys[ebi_pkg::SC_SEG];
  wire [7:0]  next_s_oe  = seg_en ? 8'hFF : cif.p4[ebi_pkg::P4_DIR +: 8];
  wire [7:0]  next_s_out = seg_en ? c.a[23:16] : cif.p4[ebi_pkg::P4_OUT +: 8];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_n                     <= 1'b1;
      low_byte_store_strobe_n  <= 1'b1;
      upper_byte_enable_n      <= 1'b1;
      addr_latch               <= 1'b0;
      muxed_port_low_out       <= 8'h00;
      muxed_port_low_oe        <= 8'h00;
      muxed_port_high_out      <= 8'h00;
      muxed_port_high_oe       <= 8'h00;
      demux_addr_port_low_out  <= 8'h00;
      demux_addr_port_low_oe   <= 8'h00;
      demux_addr_port_high_out <= 8'h00;
      demux_addr_port_high_oe  <= 8'h00;
      seg_port_out             <= 8'h00;
      seg_port_oe              <= 8'h00;
    end else begin
      rd_n                     <= next_rd_n;
      low_byte_store_strobe_n  <= next_wr_n;
      upper_byte_enable_n      <= next_ub_n;
      addr_latch               <= next_ale;
      muxed_port_low_out       <= next_l_out;
      muxed_port_low_oe        <= next_l_oe;
      muxed_port_high_out      <= next_h_out;
      muxed_port_high_oe       <= next_h_oe;
      demux_addr_port_low_out  <= p1_out[7:0];
      demux_addr_port_low_oe   <= p1_oe[7:0] & ~an_sel;
      demux_addr_port_high_out <= p1_out[15:8];
      demux_addr_port_high_oe  <= p1_oe[15:8];
      seg_port_out             <= next_s_out;
      seg_port_oe              <= next_s_oe;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_launch;
    state == ebi_pkg::ST_IDLE && cif.start;
  endsequence

  sequence s_latch_then_strobe;
    addr_latch ##1 (!addr_latch && state == ebi_pkg::ST_STRB);
  endsequence

  a_rd_only_read: assert property (!rd_n |-> state == ebi_pkg::ST_STRB && !acc_q.wr)
    else $error("read strobe outside a read strobe phase");

  a_wr_combined: assert property (
    (state == ebi_pkg::ST_STRB && acc_q.wr && !acc_q.lb) |-> !low_byte_store_strobe_n)
    else $error("combined write strobe missing");

  a_wr_low_byte: assert property (
    (state == ebi_pkg::ST_STRB && acc_q.wr && acc_q.lb)
    |-> low_byte_store_strobe_n == (acc_q.w16 && !acc_q.be[0]))
    else $error("low-byte write strobe wrong");

  a_wait_state: assert property (
    (state == ebi_pkg::ST_STRB && acc_q.rdy && rdy_s2 != rpol)
    |=> state == ebi_pkg::ST_STRB && !(acc_q.wr ? low_byte_store_strobe_n && upper_byte_enable_n
                                                : rd_n))
    else $error("wait state not inserted");

  a_no_wait_ready: assert property (
    (state == ebi_pkg::ST_STRB && (!acc_q.rdy || rdy_s2 == rpol))
    |=> state == ebi_pkg::ST_HOLD && rd_n && low_byte_store_strobe_n)
    else $error("strobe phase stretched without wait request");

  a_latch_pulse: assert property (s_launch |=> s_latch_then_strobe)
    else $error("address latch pulse missing");

  a_boot_pick: assert property (
    $rose(boot_done) |-> boot_from_external == !$past(external_boot_select_n))
    else $error("boot source not taken from pin");

  a_mux_addr_out: assert property (
    (state == ebi_pkg::ST_ADDR && acc_q.mux)
    |-> muxed_port_low_oe == 8'hFF && muxed_port_low_out == acc_q.a[7:0])
    else $error("multiplexed address not driven");

  a_demux_data_hi: assert property (
    (state == ebi_pkg::ST_STRB && acc_q.wr && !acc_q.mux && acc_q.w16)
    |-> muxed_port_high_oe == 8'hFF && muxed_port_high_out == acc_q.d[15:8])
    else $error("demultiplexed high data byte not driven");

  a_demux_claim: assert property (any_demux |=> demux_addr_port_high_oe == 8'hFF)
    else $error("demux address port released");

  a_analog_wins: assert property (
    ##1 (demux_addr_port_low_oe & $past(an_sel)) == 8'h00)
    else $error("analog input driven by address");

  a_upper_strobe: assert property (
    (state == ebi_pkg::ST_STRB && acc_q.wr && acc_q.lb && acc_q.w16 && acc_q.be[1])
    |-> !upper_byte_enable_n)
    else $error("upper-byte write strobe missing");

  a_segment_out: assert property (seg_en |=> seg_port_oe == 8'hFF)
    else $error("segment port not driven");
endmodule // ebi_top

// File: tb/ebi_mem_model.sv
`timescale 1ns/1ps
module ebi_mem_model (
  input  wire logic        hclk,     // cpu clock
  input  wire logic        rd_n,     // read strobe
  input  wire logic        wr_n,     // low write strobe
  input  wire logic        ale,      // address latch
  input  wire logic [15:0] ad_out,   // device drive
  input  wire logic [15:0] ad_oe,    // device enable
  input  wire logic [3:0]  waits,    // ready hold-off
  input  wire logic        rdy_high, // ready active level
  output logic [15:0]      ad_in,    // wire level
  output logic             ready_in, // ready to device
  output logic [15:0]      last_wr   // data seen at write
);
  logic [15:0] a = 16'h0;
  logic [15:0] q = 16'h0;
  logic [3:0]  cnt = 4'hF;
  always @(posedge hclk) begin
    q <= ad_in;
    if (!wr_n) last_wr <= ad_out;
    if (ale) begin
      a   <= ad_out;
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end
  wire strobe_on = !(rd_n && wr_n);
  // ready only inside a strobe, so a count left from the last access never leaks in
  assign ready_in = (strobe_on && cnt >= waits) ? rdy_high : !rdy_high;
  // released lines toggle rather than hold their last level
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & (!rd_n ? (a ^ 16'hA5C3) : ~q));
endmodule // ebi_mem_model

// File: tb/ebi_top_test.sv
`timescale 1ns/1ps
module ebi_top_test;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dp_rd = 1'b0;
  logic        rdy_high = 1'b1, boot_n = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, last_rd = 32'h0, hrdata;
  logic [3:0]  waits = 4'h0;
  logic [15:0] rnd = 16'h3378, a0, ad_in, last_wr;
  wire  [15:0] ad_out, ad_oe;
  logic [7:0]  dl_o, dl_e, dh_o, dh_e, sg_o, sg_e;
  logic        hreadyout, hresp, rd_n, wr_n, ub_n, ale, ready_in, boot_ext, clk_pin;
  int          n_errors = 0, checked = 0, n_rd, n_wl, n_ub, n_ale, n0;
  logic [31:0] q_e[$], q_m[$];
  string       q_n[$];
  time         t0;
  always #12.5 hclk = ~hclk;
  ebi_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rd_n(rd_n), .low_byte_store_strobe_n(wr_n),
    .upper_byte_enable_n(ub_n), .addr_latch(ale), .ready_in(ready_in),
    .external_boot_select_n(boot_n), .boot_from_external(boot_ext), .system_clock_pin(clk_pin),
    .muxed_port_low_in(ad_in[7:0]), .muxed_port_low_out(ad_out[7:0]),
    .muxed_port_low_oe(ad_oe[7:0]), .muxed_port_high_in(ad_in[15:8]),
    .muxed_port_high_out(ad_out[15:8]), .muxed_port_high_oe(ad_oe[15:8]),
    .demux_addr_port_low_in(~dl_o), .demux_addr_port_low_out(dl_o),
    .demux_addr_port_low_oe(dl_e), .demux_addr_port_high_in(~dh_o),
    .demux_addr_port_high_out(dh_o), .demux_addr_port_high_oe(dh_e),
    .seg_port_in(~sg_o), .seg_port_out(sg_o), .seg_port_oe(sg_e));
  ebi_mem_model i_mem (.hclk(hclk), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .ad_out(ad_out),
    .ad_oe(ad_oe), .waits(waits), .rdy_high(rdy_high), .ad_in(ad_in), .ready_in(ready_in),
    .last_wr(last_wr));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input string nm);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata, dp_rd} <= {1'b0, 2'b00, d, !w};
    if (!w) begin
      q_e.push_back(e);
      q_m.push_back(m);
      q_n.push_back(nm);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    dp_rd <= 1'b0;
    #1;
  endtask
  // one external access; waits for its latch pulse, then for busy to drop
  task automatic acc(input logic [31:0] cmd);
    {n_rd, n_wl, n_ub, n_ale} = '0;
    bus(1'b1, 8'h20, cmd, 0, 0, "");
    do bus(1'b0, 8'h24, 0, 0, 0, ""); while (last_rd[0] !== 1'b0 || n_ale == 0);
  endtask
  function automatic logic [15:0] xorshift(input logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    return x ^ (x << 8);
  endfunction
  always @(posedge hclk) begin
    if (!rd_n) n_rd++;
    if (!wr_n) n_wl++;
    if (!ub_n) n_ub++;
    if (ale) n_ale++;
    if (dp_rd) begin
      last_rd = hrdata;
      if (q_m[0] != 0) chk(q_n[0], q_e[0] & q_m[0], hrdata & q_m[0]);
      void'(q_e.pop_front());
      void'(q_m.pop_front());
      void'(q_n.pop_front());
    end
  end
  initial begin
    #(25 * 20000);
    n_errors++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 chk("boot_pin", 1, boot_ext);
    bus(0, 8'h24, 0, 32'h2, 32'h2, "stat_boot");
    bus(0, 8'h04, 0, 32'h3, 32'hFFFF_FFFF, "range0_reset");
    $display("end reset");
    rnd = xorshift(rnd);
    a0 = rnd;
    bus(1, 8'h18, {8'h0, 8'h12, a0}, 0, 0, "");
    acc(32'h6);
    bus(0, 8'h24, 0, {a0 ^ 16'hA5C3, 16'h0}, 32'hFFFF_0000, "read_data");
    chk("read_strobes", 1, n_rd);
    chk("latch_pulses", 1, n_ale);
    rnd = xorshift(rnd);
    bus(1, 8'h1C, {16'h0, rnd}, 0, 0, "");
    acc(32'h7);
    chk("wr_strobes", 1, n_wl);
    chk("wr_data", rnd, last_wr);
    chk("ub_enable", 3, n_ub);
    $display("end combined");
    bus(1, 8'h00, 32'h1, 0, 0, "");
    acc(32'h5);
    chk("lb_high_only", 0, n_wl);
    chk("ub_strobe", 1, n_ub);
    acc(32'h3);
    chk("lb_low_only", 1, n_wl);
    chk("ub_idle", 0, n_ub);
    bus(1, 8'h04, 32'h1, 0, 0, "");
    acc(32'h5);
    chk("lb_8bit", 1, n_wl);
    $display("end low byte");
    bus(1, 8'h04, 32'h7, 0, 0, "");
    for (int p = 0; p < 2; p++) begin
      rdy_high <= p[0];
      bus(1, 8'h00, {30'h0, p[0], 1'b0}, 0, 0, "");
      waits <= 4'h0;
      acc(32'h6);
      n0 = n_rd;
      waits <= 4'h3;
      acc(32'h6);
      chk("wait_states", n0 + 3, n_rd);
    end
    $display("end ready");
    bus(1, 8'h00, 32'h0000_0204, 0, 0, "");
    @(posedge clk_pin) t0 = $time;
    @(posedge clk_pin) chk("clk_period", 6, ($time - t0) / 25);
    $display("end clock");
    bus(1, 8'h04, 32'h2, 0, 0, "");
    bus(1, 8'h00, 32'h0101_0000, 0, 0, "");
    rnd = xorshift(rnd);
    bus(1, 8'h1C, {16'h0, rnd}, 0, 0, "");
    acc(32'h7);
    chk("demux_data", rnd, last_wr);
    chk("addr_high", 8'h12, sg_o);
    chk("seg_oe", 8'hFF, sg_e);
    chk("demux_oe", 8'hFF, dh_e);
    chk("demux_addr", a0, {dh_o, dl_o});
    chk("analog_oe", 8'hFE, dl_e);
    bus(1, 8'h08, 32'h1, 0, 0, "");
    bus(1, 8'h10, 32'h0012_0014, 0, 0, "");
    acc(32'h6);
    bus(0, 8'h24, 0, {8'h00, a0[7:0] ^ 8'hC3, 16'h0}, 32'hFFFF_0000, "window_pick");
    bus(1, 8'h28, 32'h0000_000F, 0, 0, "");
    bus(0, 8'h28, 0, 32'hF, 32'hFF, "dir_read");
    chk("dir_oe", 16'h000F, ad_oe);
    $display("end ports");
    @(posedge hclk);
    {hresetn, boot_n} <= 2'b01;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 chk("boot_high", 0, boot_ext);
    bus(0, 8'h04, 0, 32'h3, 32'hFFFF_FFFF, "range0_again");
    $display("end second reset");
    close_out();
  end
endmodule // ebi_top_test
